/* File: ccpd_power_ctrl.sv */
`timescale 1ns/10ps
module ccpd_power_ctrl
    import ccpd_pkg::*;
#(
    parameter int QUIET_CYCLES = RELOAD_QUIET_CYC
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    input wire logic sleep_pin_n,
    input wire logic nvm_sel_pin,
    input wire logic cp_event_pin,
    input wire logic [NUM_CH-1:0] ch_out_low_pin,
    input wire logic nvm_restore_done,
    output logic nvm_restore_req,
    output logic pll_off,
    output logic vco_off,
    output logic dist_bias_off,
    output logic [NUM_CH-1:0] div_off,
    output logic [NUM_DRV-1:0] drv_off,
    output logic outputs_quiet
);

    // ************************************************************
    // decode helpers
    // ************************************************************
    function automatic logic is_drv(input logic [ADDR_W-1:0] a, input int i);
        return a == (REG_DRV_BASE + ADDR_W'(i));
    endfunction : is_drv

    function automatic logic is_ch(input logic [ADDR_W-1:0] a, input int k);
        return a == (REG_CH_BASE + ADDR_W'(REG_CH_STRIDE * ADDR_W'(k)));
    endfunction : is_ch

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    logic sleep_lvl;
    logic nvm_sel_lvl;
    logic cp_lvl;
    logic [NUM_CH-1:0] ch_low;
    logic cp_prev;
    logic cp_edge;

    ccpd_pin_sync #(
        .W(NUM_CH + 3),
        .RST_VAL({{NUM_CH{1'b0}}, 3'h4})
    ) u_sync (
        .clock(clock),
        .resetn(resetn),
        .pin_in({ch_out_low_pin, sleep_pin_n, nvm_sel_pin, cp_event_pin}),
        .level_out({ch_low, sleep_lvl, nvm_sel_lvl, cp_lvl})
    );

    assign cp_edge = cp_lvl && !cp_prev;

    // ************************************************************
    // written (buffered) and active registers
    // ************************************************************
    logic [7:0] buf_pll;
    logic [7:0] buf_dist;
    logic [7:0] buf_drv [NUM_DRV];
    logic [7:0] buf_ch [NUM_CH];
    logic [7:0] next_buf_pll;
    logic [7:0] next_buf_dist;
    logic [7:0] next_buf_drv [NUM_DRV];
    logic [7:0] next_buf_ch [NUM_CH];
    logic update_pend;
    logic next_update_pend;
    ccpd_pll_mode_t act_pll;
    ccpd_pll_mode_t next_act_pll;
    logic act_dist;
    logic next_act_dist;
    logic [NUM_DRV-1:0] act_drv_pd;
    logic [NUM_DRV-1:0] next_act_drv_pd;
    logic [NUM_CH-1:0] act_ch_pd;
    logic [NUM_CH-1:0] next_act_ch_pd;

    // writes stay legal in sleep; they land in the buffer and act on update
    always_comb begin
        next_buf_pll = buf_pll;
        next_buf_dist = buf_dist;
        next_buf_drv = buf_drv;
        next_buf_ch = buf_ch;
        next_update_pend = 1'b0;
        if (reg_wr) begin
            if (reg_addr == REG_PLL_CFG) begin
                next_buf_pll = reg_wdata;
            end else if (reg_addr == REG_DIST_CFG) begin
                next_buf_dist = reg_wdata;
            end else if (reg_addr == REG_UPDATE) begin
                next_update_pend = reg_wdata[UPDATE_BIT];
            end
            for (int i = 0; i < NUM_DRV; i++) begin
                if (is_drv(reg_addr, i)) begin
                    next_buf_drv[i] = reg_wdata;
                end
            end
            for (int k = 0; k < NUM_CH; k++) begin
                if (is_ch(reg_addr, k)) begin
                    next_buf_ch[k] = reg_wdata;
                end
            end
        end
    end

    always_comb begin
        next_act_pll = act_pll;
        next_act_dist = act_dist;
        next_act_drv_pd = act_drv_pd;
        next_act_ch_pd = act_ch_pd;
        if (update_pend) begin
            next_act_pll = ccpd_pll_mode_t'(buf_pll[PLL_MODE_LSB +: 2]);
            next_act_dist = buf_dist[DIST_PD_BIT];
            for (int i = 0; i < NUM_DRV; i++) begin
                next_act_drv_pd[i] = buf_drv[i][DRV_PD_BIT];
            end
            for (int k = 0; k < NUM_CH; k++) begin
                next_act_ch_pd[k] = buf_ch[k][CH_PD_BIT];
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            buf_pll <= PLL_CFG_RST;
            buf_dist <= DIST_CFG_RST;
            for (int i = 0; i < NUM_DRV; i++) begin
                buf_drv[i] <= DRV_CFG_RST;
            end
            for (int k = 0; k < NUM_CH; k++) begin
                buf_ch[k] <= CH_CFG_RST;
            end
            update_pend <= 1'b0;
            act_pll <= CCPD_PLL_ON;
            act_dist <= 1'b0;
            act_drv_pd <= '0;
            act_ch_pd <= '0;
        end else begin
            buf_pll <= next_buf_pll;
            buf_dist <= next_buf_dist;
            buf_drv <= next_buf_drv;
            buf_ch <= next_buf_ch;
            update_pend <= next_update_pend;
            act_pll <= next_act_pll;
            act_dist <= next_act_dist;
            act_drv_pd <= next_act_drv_pd;
            act_ch_pd <= next_act_ch_pd;
        end
    end

    // ************************************************************
    // pll power-down
    // ************************************************************
    logic pll_wait;
    logic pll_sync_off;
    logic next_pll_wait;
    logic next_pll_sync_off;
    logic asleep;

    assign asleep = !sleep_lvl;

    always_comb begin
        next_pll_wait = pll_wait;
        next_pll_sync_off = pll_sync_off;
        if (update_pend) begin
            // a fresh synchronous-mode update re-arms the wait or keeps an already-off pll off; other modes clear both
            next_pll_wait = (buf_pll[PLL_MODE_LSB +: 2] == CCPD_PLL_SYNC_PD) && !pll_sync_off;
            next_pll_sync_off = (buf_pll[PLL_MODE_LSB +: 2] == CCPD_PLL_SYNC_PD) && pll_sync_off;
        end else if (pll_wait && cp_edge) begin
            next_pll_wait = 1'b0;
            next_pll_sync_off = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            pll_wait <= 1'b0;
            pll_sync_off <= 1'b0;
            cp_prev <= 1'b0;
        end else begin
            pll_wait <= next_pll_wait;
            pll_sync_off <= next_pll_sync_off;
            cp_prev <= cp_lvl;
        end
    end

    // ************************************************************
    // reload from nonvolatile memory
    // ************************************************************
    ccpd_reload_state_t rl_state;
    ccpd_reload_state_t next_rl_state;
    logic reload_bit;
    logic next_reload_bit;
    logic quiet_start;
    logic quiet_busy;

    always_comb begin
        next_rl_state = rl_state;
        next_reload_bit = reload_bit;
        quiet_start = 1'b0;
        case (rl_state)
            CCPD_RL_IDLE: begin
                if (reload_bit) begin
                    next_rl_state = CCPD_RL_LOAD;
                end
            end
            CCPD_RL_LOAD: begin
                if (nvm_restore_done) begin
                    next_reload_bit = 1'b0;
                    quiet_start = 1'b1;
                    next_rl_state = CCPD_RL_QUIET;
                end
            end
            CCPD_RL_QUIET: begin
                if (!quiet_busy && !quiet_start) begin
                    next_rl_state = CCPD_RL_IDLE;
                end
            end
            default: begin
                next_rl_state = CCPD_RL_IDLE;
            end
        endcase
        // a new request beside the self-clear wins over the clear
        if (reg_wr && reg_addr == REG_RELOAD && reg_wdata[RELOAD_BIT] && !nvm_sel_lvl) begin
            next_reload_bit = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            rl_state <= CCPD_RL_IDLE;
            reload_bit <= 1'b0;
        end else begin
            rl_state <= next_rl_state;
            reload_bit <= next_reload_bit;
        end
    end

    ccpd_quiet_timer #(
        .CYCLES(QUIET_CYCLES)
    ) u_quiet (
        .clock(clock),
        .resetn(resetn),
        .start(quiet_start),
        .busy(quiet_busy)
    );

    // ************************************************************
    // divider and driver gating, changed only at a low output phase
    // ************************************************************
    logic quiet_now;
    logic [NUM_CH-1:0] want_div_off;
    logic [NUM_DRV-1:0] want_drv_off;
    logic [NUM_CH-1:0] next_div_off;
    logic [NUM_DRV-1:0] next_drv_off;

    assign quiet_now = (rl_state != CCPD_RL_IDLE);

    always_comb begin
        for (int k = 0; k < NUM_CH; k++) begin
            want_div_off[k] = act_ch_pd[k] || asleep;
        end
        for (int i = 0; i < NUM_DRV; i++) begin
            // channel off or sleep overrides the driver's own bit
            want_drv_off[i] = act_drv_pd[i] || want_div_off[i / DRV_PER_CH] || quiet_now;
        end
        next_div_off = div_off;
        next_drv_off = drv_off;
        for (int k = 0; k < NUM_CH; k++) begin
            if (ch_low[k]) begin
                next_div_off[k] = want_div_off[k];
                next_drv_off[k*DRV_PER_CH +: DRV_PER_CH] = want_drv_off[k*DRV_PER_CH +: DRV_PER_CH];
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            div_off <= '0;
            drv_off <= '0;
            pll_off <= 1'b0;
            vco_off <= 1'b0;
            dist_bias_off <= 1'b0;
            outputs_quiet <= 1'b0;
            nvm_restore_req <= 1'b0;
        end else begin
            div_off <= next_div_off;
            drv_off <= next_drv_off;
            // sleep and asynchronous mode act at once, not at a pump event
            pll_off <= asleep || (act_pll == CCPD_PLL_ASYNC_PD) || pll_sync_off;
            vco_off <= asleep;
            dist_bias_off <= act_dist;
            outputs_quiet <= quiet_now;
            nvm_restore_req <= (next_rl_state == CCPD_RL_LOAD);
        end
    end

    // ************************************************************
    // read back
    // ************************************************************
    logic [7:0] rd_val;
    logic [7:0] next_rdata;

    always_comb begin
        rd_val = 8'h00;
        if (reg_addr == REG_PLL_CFG) begin
            rd_val = buf_pll;
        end else if (reg_addr == REG_DIST_CFG) begin
            rd_val = buf_dist;
        end else if (reg_addr == REG_RELOAD) begin
            rd_val = 8'(reload_bit) << RELOAD_BIT;
        end else if (reg_addr == REG_STATUS) begin
            rd_val[ST_ASLEEP_BIT] = asleep;
            rd_val[ST_PLL_OFF_BIT] = pll_off;
            rd_val[ST_RESTORE_BIT] = (rl_state == CCPD_RL_LOAD);
            rd_val[ST_QUIET_BIT] = quiet_now;
        end
        for (int i = 0; i < NUM_DRV; i++) begin
            if (is_drv(reg_addr, i)) begin
                rd_val = buf_drv[i];
            end
        end
        for (int k = 0; k < NUM_CH; k++) begin
            if (is_ch(reg_addr, k)) begin
                rd_val = buf_ch[k];
            end
        end
        next_rdata = reg_rd ? rd_val : 8'h00;
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

endmodule : ccpd_power_ctrl

/* File: ccpd_pkg.sv */
package ccpd_pkg;

    // ************************************************************
    // sizes
    // ************************************************************
    localparam int NUM_CH = 4;
    localparam int DRV_PER_CH = 3;
    localparam int NUM_DRV = NUM_CH * DRV_PER_CH;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;

    // ************************************************************
    // register offsets
    // ************************************************************
    localparam logic [11:0] REG_PLL_CFG = 12'h010;
    localparam logic [11:0] REG_DRV_BASE = 12'h0f0;
    localparam logic [11:0] REG_CH_BASE = 12'h192;
    localparam logic [11:0] REG_CH_STRIDE = 12'h003;
    localparam logic [11:0] REG_DIST_CFG = 12'h230;
    localparam logic [11:0] REG_UPDATE = 12'h232;
    localparam logic [11:0] REG_STATUS = 12'h3f0;
    localparam logic [11:0] REG_RELOAD = 12'hb02;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int PLL_MODE_LSB = 0;
    localparam int DIST_PD_BIT = 1;
    localparam int DRV_PD_BIT = 0;
    localparam int CH_PD_BIT = 2;
    localparam int UPDATE_BIT = 0;
    localparam int RELOAD_BIT = 1;
    localparam int ST_ASLEEP_BIT = 0;
    localparam int ST_PLL_OFF_BIT = 1;
    localparam int ST_RESTORE_BIT = 2;
    localparam int ST_QUIET_BIT = 3;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [7:0] PLL_CFG_RST = 8'h00;
    localparam logic [7:0] DRV_CFG_RST = 8'h00;
    localparam logic [7:0] CH_CFG_RST = 8'h00;
    localparam logic [7:0] DIST_CFG_RST = 8'h00;

    // ************************************************************
    // pll power-down modes
    // ************************************************************
    typedef enum logic [1:0] {
        CCPD_PLL_ON = 2'h0,
        CCPD_PLL_ASYNC_PD = 2'h1,
        CCPD_PLL_ON_ALT = 2'h2,
        CCPD_PLL_SYNC_PD = 2'h3
    } ccpd_pll_mode_t;

    typedef enum logic [1:0] {
        CCPD_RL_IDLE = 2'h0,
        CCPD_RL_LOAD = 2'h1,
        CCPD_RL_QUIET = 2'h3
    } ccpd_reload_state_t;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_KHZ = 50000;
    localparam int RELOAD_QUIET_MS = 20;
    localparam int RELOAD_QUIET_CYC = RELOAD_QUIET_MS * CLK_KHZ;

endpackage : ccpd_pkg

/* File: ccpd_pin_sync.sv */
`timescale 1ns/10ps
module ccpd_pin_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] level_out
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] next_level;

    always_comb begin
        next_level = level_out;
        for (int i = 0; i < W; i++) begin
            // accept a change only once the two later stages agree
            if (s2[i] == s3[i]) begin
                next_level[i] = s3[i];
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            s1 <= RST_VAL;
            s2 <= RST_VAL;
            s3 <= RST_VAL;
            level_out <= RST_VAL;
        end else begin
            s1 <= pin_in;
            s2 <= s1;
            s3 <= s2;
            level_out <= next_level;
        end
    end
endmodule : ccpd_pin_sync

/* File: ccpd_quiet_timer.sv */
`timescale 1ns/10ps
module ccpd_quiet_timer #(
    parameter int CYCLES = 1000000
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic start,
    output logic busy
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LOAD_VAL = CW'(CYCLES);

    logic [CW-1:0] count;
    logic [CW-1:0] next_count;

    always_comb begin
        next_count = count;
        if (start) begin
            next_count = LOAD_VAL;
        end else if (count != '0) begin
            next_count = count - CW'(1);
        end
    end

    assign busy = (count != '0);

    always_ff @(posedge clock) begin
        if (!resetn) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end
endmodule : ccpd_quiet_timer

/* File: ccpd_far_model.sv */
`timescale 1ns/10ps
module ccpd_far_model
    import ccpd_pkg::*;
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic cp_run,
    input wire logic slow,
    input wire logic nvm_restore_req,
    output logic nvm_restore_done,
    output logic cp_event_pin,
    output logic [NUM_CH-1:0] ch_out_low_pin
);
    logic [6:0] tick;
    logic [4:0] wait_cnt;

    // channel i output sits low for 2^(i+3) cycles at a time
    assign ch_out_low_pin = tick[6:3];

    always_ff @(posedge clock) begin
        if (!resetn) begin
            tick <= 7'h00;
            wait_cnt <= 5'h00;
            cp_event_pin <= 1'b0;
            nvm_restore_done <= 1'b0;
        end else begin
            tick <= tick + 7'h01;
            // two cycles wide: a one-cycle pulse never passes the agreeing pin filter
            cp_event_pin <= cp_run && tick[2:1] == 2'h3;
            wait_cnt <= nvm_restore_req ? wait_cnt + 5'h01 : 5'h00;
            // slow memory answers after 14 cycles, prompt after 2
            nvm_restore_done <= nvm_restore_req && wait_cnt == (slow ? 5'h0e : 5'h02);
        end
    end
endmodule : ccpd_far_model

/* File: ccpd_power_ctrl_asserts.sv */
`timescale 1ns/10ps
module ccpd_power_ctrl_asserts
    import ccpd_pkg::*;
#(
    parameter int QUIET_CYCLES = RELOAD_QUIET_CYC
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [DATA_W-1:0] reg_rdata,
    input wire logic sleep_pin_n,
    input wire logic nvm_sel_pin,
    input wire logic cp_event_pin,
    input wire logic [NUM_CH-1:0] ch_out_low_pin,
    input wire logic nvm_restore_done,
    input wire logic nvm_restore_req,
    input wire logic pll_off,
    input wire logic vco_off,
    input wire logic dist_bias_off,
    input wire logic [NUM_CH-1:0] div_off,
    input wire logic [NUM_DRV-1:0] drv_off,
    input wire logic outputs_quiet
);
    logic [3:0] slp;
    logic [3:0] awk;
    int qcnt;

    default clocking dc @(posedge clock);
    endclocking
    default disable iff (!resetn);

    // ********
    // helper counters
    // ********
    always_ff @(posedge clock) begin
        if (!resetn) begin
            slp <= 4'h0;
            awk <= 4'h0;
            qcnt <= 0;
        end else begin
            slp <= sleep_pin_n ? 4'h0 : slp + {3'h0, slp != 4'hf};
            awk <= !sleep_pin_n ? 4'h0 : awk + {3'h0, awk != 4'hf};
            qcnt <= (nvm_restore_req || !outputs_quiet) ? 0 : qcnt + 1;
        end
    end

    // ********
    // checks
    // ********
    AST_SLEEP_OFF: assert property (slp >= 4'h6 |-> pll_off && vco_off)
        else $error("pll or vco on in sleep");
    AST_SLEEP_STAT: assert property (reg_rd && reg_addr == REG_STATUS && slp >= 4'h6 |=> reg_rdata[0])
        else $error("status not asleep");
    AST_WAKE_STAT: assert property (reg_rd && reg_addr == REG_STATUS && awk >= 4'h8 |=> !reg_rdata[0])
        else $error("status asleep while awake");
    AST_SLEEP_DRV: assert property ((slp >= 4'h6 && ch_out_low_pin[0]) [*6] |-> &drv_off[2:0] && div_off[0])
        else $error("channel 0 active in sleep");
    AST_NO_RUNT: assert property ($changed(drv_off[0]) |-> $past(ch_out_low_pin[0], 3) ||
        $past(ch_out_low_pin[0], 4) || $past(ch_out_low_pin[0], 5) || $past(ch_out_low_pin[0], 6))
        else $error("driver 0 switched while output high");
    AST_CH_DRV: assert property ((div_off[1] && ch_out_low_pin[1]) [*6] |-> &drv_off[5:3])
        else $error("driver on with channel off");
    AST_RELOAD_GO: assert property ((!nvm_sel_pin && !nvm_restore_req && !outputs_quiet) [*6] ##0
        (reg_wr && reg_addr == REG_RELOAD && reg_wdata[RELOAD_BIT]) |-> ##2 nvm_restore_req)
        else $error("reload not requested");
    AST_RELOAD_IGN: assert property ((nvm_sel_pin && !nvm_restore_req) [*6] ##0
        (reg_wr && reg_addr == REG_RELOAD) |=> !nvm_restore_req [*4])
        else $error("reload taken with select high");
    AST_QUIET_LEN: assert property ($fell(outputs_quiet) |-> qcnt >= QUIET_CYCLES)
        else $error("quiet time too short");

    CVR_SLEEP: cover property (slp == 4'hf);
    CVR_RELOAD: cover property ($fell(nvm_restore_req));
    CVR_CH_OFF: cover property ($rose(div_off[1]));
endmodule : ccpd_power_ctrl_asserts

/* File: ccpd_power_ctrl_tb.sv */
`timescale 1ns/10ps
module ccpd_power_ctrl_tb
    import ccpd_pkg::*;
;
    localparam int QC = 20;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic [11:0] reg_addr = 12'h000;
    logic [11:0] a;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] d, reg_rdata;
    logic reg_wr = 1'b0, reg_rd = 1'b0, sleep_pin_n = 1'b1, nvm_sel_pin = 1'b0, cp_run = 1'b0, slow = 1'b0;
    logic cp_event_pin, nvm_restore_done, nvm_restore_req, pll_off, vco_off, dist_bias_off, outputs_quiet;
    logic [3:0] div_off, ch_out_low_pin;
    logic [11:0] drv_off;
    int err_total = 0, num_checks = 0, cycles = 0, n, k;
    integer seed = 32'h9572;

    ccpd_power_ctrl #(.QUIET_CYCLES(QC)) ccpd_power_ctrl_i (.clock, .resetn, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .sleep_pin_n, .nvm_sel_pin, .cp_event_pin, .ch_out_low_pin, .nvm_restore_done,
        .nvm_restore_req, .pll_off, .vco_off, .dist_bias_off, .div_off, .drv_off, .outputs_quiet);
    ccpd_far_model ccpd_far_model_i (.clock, .resetn, .cp_run, .slow, .nvm_restore_req, .nvm_restore_done,
        .cp_event_pin, .ch_out_low_pin);

    initial begin
        forever #10 clock = ~clock;
    end

    // ********
    // tasks
    // ********
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : finish_test
    task automatic check_out(input string nm, input logic [11:0] exp, input logic [11:0] seen);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check_out
    task automatic cyc(input int c);
        repeat (c) @(posedge clock);
        #1;
    endtask : cyc
    task automatic wr(input logic [11:0] wa, input logic [7:0] wd);
        @(posedge clock);
        reg_addr <= wa;
        reg_wdata <= wd;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic apply(input logic [11:0] wa, input logic [7:0] wd);
        wr(wa, wd);
        wr(REG_UPDATE, 8'h01);
    endtask : apply
    task automatic check_rd(input logic [11:0] ra, input logic [7:0] exp);
        @(posedge clock);
        reg_addr <= ra;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 check_out("read data", {4'h0, exp}, {4'h0, reg_rdata});
    endtask : check_rd
    task automatic pins(input logic s, input logic e, input logic c, input logic w);
        @(posedge clock);
        sleep_pin_n <= s;
        nvm_sel_pin <= e;
        cp_run <= c;
        slow <= w;
    endtask : pins
    // bounded: slowest channel stays high 64 cycles at a time
    task automatic wait_out(input logic [11:0] edrv, input logic [3:0] ediv);
        for (n = 0; n < 200 && (drv_off !== edrv || div_off !== ediv); n++) cyc(1);
        check_out("driver off", edrv, drv_off);
        check_out("divider off", {8'h00, ediv}, {8'h00, div_off});
    endtask : wait_out

    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            finish_test();
        end
    end

    // ********
    // main sequence
    // ********
    initial begin
        repeat (5) @(posedge clock);
        resetn <= 1'b1;
        check_rd(REG_PLL_CFG, PLL_CFG_RST);
        check_rd(REG_DIST_CFG, DIST_CFG_RST);
        check_rd(REG_DRV_BASE, DRV_CFG_RST);
        check_rd(REG_CH_BASE, CH_CFG_RST);
        check_rd(12'h7ff, 8'h00);
        for (k = 0; k < 8; k++) begin
            a = k[0] ? REG_DRV_BASE + 12'($unsigned($random(seed)) % 12)
                : REG_CH_BASE + REG_CH_STRIDE * 12'($unsigned($random(seed)) % 4);
            d = 8'($random(seed));
            wr(a, d);
            check_rd(a, d);
            wr(a, 8'h00);
        end
        $display("test registers done");
        k = $unsigned($random(seed)) % 12;
        apply(REG_DRV_BASE + 12'(k), 8'h01);
        wait_out(12'h001 << k, 4'h0);
        apply(REG_DRV_BASE + 12'(k), 8'h00);
        wait_out(12'h000, 4'h0);
        k = 1 + $unsigned($random(seed)) % 3;
        apply(REG_CH_BASE + REG_CH_STRIDE * 12'(k), 8'h04);
        wait_out(12'h007 << (3 * k), 4'h1 << k);
        apply(REG_CH_BASE + REG_CH_STRIDE * 12'(k), 8'h00);
        wait_out(12'h000, 4'h0);
        apply(REG_DIST_CFG, 8'h02);
        cyc(4);
        check_out("dist off", 12'h001, {11'h0, dist_bias_off});
        apply(REG_DIST_CFG, 8'h00);
        cyc(4);
        check_out("dist off", 12'h000, {11'h0, dist_bias_off});
        $display("test power bits done");
        // charge pump held still, so the synchronous mode must not act yet
        for (k = 0; k < 4; k++) begin
            apply(REG_PLL_CFG, 8'(k));
            cyc(12);
            check_out("pll off", {11'h0, k == 1}, {11'h0, pll_off});
        end
        pins(1'b1, 1'b0, 1'b1, 1'b0);
        cyc(20);
        check_out("pll off", 12'h001, {11'h0, pll_off});
        apply(REG_PLL_CFG, 8'h00);
        pins(1'b1, 1'b0, 1'b0, 1'b0);
        cyc(8);
        check_out("pll off", 12'h000, {11'h0, pll_off});
        $display("test pll done");
        pins(1'b0, 1'b0, 1'b0, 1'b0);
        cyc(8);
        check_out("pll vco off", 12'h003, {10'h0, pll_off, vco_off});
        check_rd(REG_STATUS, 8'h03);
        wait_out(12'hfff, 4'hf);
        apply(REG_DIST_CFG, 8'h02);
        check_rd(REG_DIST_CFG, 8'h02);
        pins(1'b1, 1'b0, 1'b0, 1'b0);
        wait_out(12'h000, 4'h0);
        check_out("awake", 12'h001, {9'h0, pll_off, vco_off, dist_bias_off});
        check_rd(REG_STATUS, 8'h00);
        apply(REG_DIST_CFG, 8'h00);
        $display("test sleep done");
        pins(1'b1, 1'b1, 1'b0, 1'b0);
        cyc(6);
        wr(REG_RELOAD, 8'h02);
        cyc(6);
        check_out("reload ignored", 12'h000, {10'h0, nvm_restore_req, outputs_quiet});
        check_rd(REG_RELOAD, 8'h00);
        for (k = 0; k < 2; k++) begin
            pins(1'b1, 1'b0, 1'b0, k[0]);
            cyc(6);
            wr(REG_RELOAD, 8'h02);
            cyc(2);
            check_out("restore", 12'h003, {10'h0, nvm_restore_req, outputs_quiet});
            for (n = 0; n < 60 && nvm_restore_req === 1'b1; n++) cyc(1);
            for (n = 0; n < 200 && outputs_quiet === 1'b1; n++) cyc(1);
            check_out("quiet span", 12'h001, {11'h0, n >= QC && n <= QC + 4});
            check_rd(REG_RELOAD, 8'h00);
        end
        $display("test reload done");
        finish_test();
    end
endmodule : ccpd_power_ctrl_tb

bind ccpd_power_ctrl ccpd_power_ctrl_asserts #(.QUIET_CYCLES(QUIET_CYCLES)) ccpd_power_ctrl_asserts_i (.clock,
    .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .sleep_pin_n, .nvm_sel_pin, .cp_event_pin,
    .ch_out_low_pin, .nvm_restore_done, .nvm_restore_req, .pll_off, .vco_off, .dist_bias_off, .div_off,
    .drv_off, .outputs_quiet);
